// *** logic/cpm_core.sv ***
// Mode sequencing, wakeup, frame-valid timer link and bit timing for CAN.
// Assumes the protocol engine reports activity and frame ends on mclk.
`timescale 1ns/100ps
`include "cpm_regs.svh"
module cpm_core
	import cpm_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// CPU state
	input  wire logic       cpu_stop,
	// Control bits
	input  wire logic       sleep_request_set,
	input  wire logic       sleep_request_clr,
	input  wire logic       soft_reset_set,
	input  wire logic       soft_reset_clr,
	input  wire logic       wakeup_int_enable,
	input  wire logic       wakeup_filter_select,
	input  wire logic       timer_link_enable,
	input  wire logic       clock_source_select,
	input  wire logic       cfg_we,
	input  wire logic [5:0] cfg_prescale,
	input  wire logic [3:0] cfg_seg1,
	input  wire logic [2:0] cfg_seg2,
	input  wire logic [1:0] cfg_sjw,
	// Clock enables
	input  wire logic       osc_ce,
	input  wire logic       pll_ce,
	// Protocol engine status
	input  wire logic       eng_tx_pending,
	input  wire logic       eng_rx_busy,
	input  wire logic       eng_bus_off,
	input  wire logic       eng_frame_valid,
	input  wire logic       eng_tx,
	// Bus pins
	input  wire logic       can_rx,
	output logic            can_tx,
	// Status and control to engine
	output logic            sleep_request,
	output logic            sleep_ack,
	output logic            soft_reset_bit,
	output logic            wakeup_irq,
	output logic            cpu_wake,
	output logic            reg_access_ok,
	output logic            proto_run,
	output logic            eng_abort,
	output logic            allow_copy,
	output logic            bus_synced,
	output logic            boff_count_en,
	output logic            tq_tick,
	output logic            bit_tick,
	output logic            sample_point,
	output logic [3:0]      first_segment_length,
	output logic [2:0]      second_segment_length,
	output logic [1:0]      sjw_length,
	output logic            capture_timer_one
);

	// Synchroniser for receive pin
	logic rx_s1, rx_s2;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_s1 <= `CPM_RECESSIVE;
			rx_s2 <= `CPM_RECESSIVE;
		end else begin
			rx_s1 <= can_rx;
			rx_s2 <= rx_s1;
		end
	end

	// Mode, control bits, filter, resync
	cpm_mode_t            mode, next_mode;
	logic                 next_sleep_request, next_soft_reset_bit;
	logic [`CPM_FILT_W-1:0] filt_cnt, next_filt_cnt;
	logic [3:0]           idle_cnt, next_idle_cnt;
	logic                 synced, next_synced;
	logic                 rx_dom, wake_evt;
	logic [5:0]           prescale, next_prescale;
	logic [3:0]           seg1_r, next_seg1;
	logic [2:0]           seg2_r, next_seg2;
	logic [1:0]           sjw_r, next_sjw;

	always_comb begin
		next_mode           = mode;
		next_sleep_request  = sleep_request;
		next_soft_reset_bit = soft_reset_bit;
		next_filt_cnt       = '0;
		next_idle_cnt       = idle_cnt;
		next_synced         = synced;
		next_prescale       = prescale;
		next_seg1           = seg1_r;
		next_seg2           = seg2_r;
		next_sjw            = sjw_r;
		rx_dom              = (rx_s2 != `CPM_RECESSIVE);
		wake_evt            = 1'b0;
		if (mode == CPM_SLEEP || mode == CPM_DOWN) begin
			if (rx_dom && wakeup_filter_select) begin
				// Saturates so a long stop never wraps the count
				next_filt_cnt = (filt_cnt == `CPM_FILT_LAST) ? filt_cnt
				                : filt_cnt + 9'h001;
				// Short glitches never reach the count
				wake_evt = (filt_cnt == `CPM_FILT_LAST);
			end else begin
				wake_evt = rx_dom;
			end
		end
		if (sleep_request_set) begin
			next_sleep_request = 1'b1;
		end else if (sleep_request_clr && sleep_ack) begin
			next_sleep_request = 1'b0;
		end
		if (soft_reset_set) begin
			next_soft_reset_bit = 1'b1;
		end else if (soft_reset_clr) begin
			next_soft_reset_bit = 1'b0;
		end
		if (soft_reset_bit && cfg_we) begin
			next_prescale = cfg_prescale;
			next_seg1     = (cfg_seg1 < 4'h3) ? 4'h3 : cfg_seg1;
			next_seg2     = (cfg_seg2 < 3'h1) ? 3'h1 : cfg_seg2;
			next_sjw      = cfg_sjw;
		end
		unique case (mode)
			CPM_NORMAL: begin
				if (soft_reset_bit) begin
					next_mode = CPM_SOFT;
				end else if (sleep_request && !eng_tx_pending
				             && !eng_rx_busy) begin
					next_mode = CPM_SLEEP;
				end
			end
			CPM_SLEEP: begin
				// Any wake cause also drops the acknowledge here
				if (wake_evt || !sleep_request || soft_reset_bit) begin
					next_mode   = soft_reset_bit ? CPM_SOFT : CPM_NORMAL;
					next_synced = 1'b0;
					next_idle_cnt = '0;
					if (wake_evt) begin
						next_sleep_request = 1'b0;
					end
				end
			end
			CPM_SOFT: begin
				if (!soft_reset_bit) begin
					next_mode   = CPM_NORMAL;
					next_synced = 1'b0;
					next_idle_cnt = '0;
				end
			end
			CPM_DOWN: begin
				next_synced   = 1'b0;
				next_idle_cnt = '0;
			end
		endcase
		// CPU stop overrides every other setting
		if (cpu_stop) begin
			next_mode = CPM_DOWN;
		end else if (mode == CPM_DOWN) begin
			next_mode = soft_reset_bit ? CPM_SOFT :
			            (sleep_request ? CPM_SLEEP : CPM_NORMAL);
		end
		if (mode == CPM_NORMAL && !synced && bit_tick) begin
			if (rx_dom) begin
				next_idle_cnt = '0;
			end else if (idle_cnt == `CPM_IDLE_BITS - 4'h1) begin
				next_synced = 1'b1;
			end else begin
				next_idle_cnt = idle_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// Reset leaves the soft reset bit set, so start stopped
			mode           <= CPM_SOFT;
			sleep_request  <= 1'b0;
			soft_reset_bit <= 1'b1;
			filt_cnt       <= '0;
			idle_cnt       <= '0;
			synced         <= 1'b0;
			prescale       <= 6'h00;
			seg1_r         <= 4'h3;
			seg2_r         <= 3'h1;
			sjw_r          <= 2'h0;
		end else begin
			mode           <= next_mode;
			sleep_request  <= next_sleep_request;
			soft_reset_bit <= next_soft_reset_bit;
			filt_cnt       <= next_filt_cnt;
			idle_cnt       <= next_idle_cnt;
			synced         <= next_synced;
			prescale       <= next_prescale;
			seg1_r         <= next_seg1;
			seg2_r         <= next_seg2;
			sjw_r          <= next_sjw;
		end
	end

	// Bit timing: prescaler, then segments
	logic       src_ce;
	logic [5:0] pre_cnt, next_pre_cnt;
	logic [4:0] q_cnt, next_q_cnt;
	cpm_seg_t   seg, next_seg;
	logic       next_tq, next_bit, next_sample;

	always_comb begin
		// Clock source select picks the quanta reference
		src_ce       = clock_source_select ? pll_ce : osc_ce;
		next_pre_cnt = pre_cnt;
		next_q_cnt   = q_cnt;
		next_seg     = seg;
		next_tq      = 1'b0;
		next_bit     = 1'b0;
		next_sample  = 1'b0;
		if (!proto_run) begin
			next_pre_cnt = '0;
			next_q_cnt   = '0;
			next_seg     = CPM_SEG_SYNC;
		end else if (src_ce) begin
			if (pre_cnt == prescale) begin
				next_pre_cnt = '0;
				next_tq      = 1'b1;
				unique case (seg)
					CPM_SEG_SYNC: begin
						next_seg   = CPM_SEG_ONE;
						next_q_cnt = '0;
					end
					CPM_SEG_ONE: begin
						if (q_cnt == {1'b0, seg1_r}) begin
							next_seg    = CPM_SEG_TWO;
							next_q_cnt  = '0;
							next_sample = 1'b1;
						end else begin
							next_q_cnt = q_cnt + 5'h01;
						end
					end
					CPM_SEG_TWO: begin
						if (q_cnt == {2'b00, seg2_r}) begin
							next_seg   = CPM_SEG_SYNC;
							next_q_cnt = '0;
							next_bit   = 1'b1;
						end else begin
							next_q_cnt = q_cnt + 5'h01;
						end
					end
					default: begin
						next_seg = CPM_SEG_SYNC;
					end
				endcase
			end else begin
				next_pre_cnt = pre_cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pre_cnt      <= '0;
			q_cnt        <= '0;
			seg          <= CPM_SEG_SYNC;
			tq_tick      <= 1'b0;
			bit_tick     <= 1'b0;
			sample_point <= 1'b0;
		end else begin
			pre_cnt      <= next_pre_cnt;
			q_cnt        <= next_q_cnt;
			seg          <= next_seg;
			tq_tick      <= next_tq;
			bit_tick     <= next_bit;
			sample_point <= next_sample;
		end
	end

	// Frame-valid pulse: armed by the frame end, then one full bit long
	logic fv_arm, next_fv_arm, fv_busy, next_fv_busy, fv_out, next_fv_out;
	always_comb begin
		next_fv_arm  = fv_arm;
		next_fv_busy = fv_busy;
		if (bit_tick) begin
			// Starting on a bit boundary keeps the pulse one bit wide
			next_fv_busy = fv_arm;
			next_fv_arm  = 1'b0;
		end
		if (eng_frame_valid && proto_run) begin
			next_fv_arm = 1'b1;
		end
		// Bit ticks stop with the protocol, so drop the pulse too
		if (!proto_run) begin
			next_fv_arm  = 1'b0;
			next_fv_busy = 1'b0;
		end
		next_fv_out = fv_busy && timer_link_enable;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fv_arm  <= 1'b0;
			fv_busy <= 1'b0;
			fv_out  <= 1'b0;
		end else begin
			fv_arm  <= next_fv_arm;
			fv_busy <= next_fv_busy;
			fv_out  <= next_fv_out;
		end
	end

	// Mode-derived outputs, plus timer capture and timing fields
	always_comb begin
		proto_run     = (mode == CPM_NORMAL);
		sleep_ack     = (mode == CPM_SLEEP);
		bus_synced    = proto_run && synced;
		// Bus-off count pauses while asleep, resumes once the bus is resynced after wake
		boff_count_en = bus_synced && eng_bus_off;
		// No copy or abort while asleep; pending ones run on wake
		allow_copy    = proto_run;
		eng_abort     = (mode == CPM_SOFT) || (mode == CPM_DOWN);
		reg_access_ok = (mode != CPM_DOWN);
		wakeup_irq    = sleep_ack && wakeup_int_enable && wake_evt;
		cpu_wake      = (mode == CPM_DOWN) && wake_evt;
		capture_timer_one     = fv_out;
		first_segment_length  = seg1_r;
		second_segment_length = seg2_r;
		sjw_length            = sjw_r;
	end

	// Transmit pin: recessive unless synced and staying in normal mode;
	// looking at the next mode keeps the first low-power cycle recessive
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			can_tx <= `CPM_RECESSIVE;
		end else if (bus_synced && next_mode == CPM_NORMAL) begin
			can_tx <= eng_tx;
		end else begin
			can_tx <= `CPM_RECESSIVE;
		end
	end

endmodule : cpm_core

// *** logic/cpm_regs.svh ***
// Constants for the CAN power-mode and bit-timing block.
// Assumes inclusion by the package and the block; definitions only.
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH
`define CPM_RECESSIVE    1'b1
`define CPM_IDLE_BITS    4'hB
`define CPM_BOFF_GROUPS  8'h80
`define CPM_FILT_NS      2000
`define CPM_CLK_NS       4
`define CPM_FILT_CYC     ((`CPM_FILT_NS + `CPM_CLK_NS - 1) / `CPM_CLK_NS)
`define CPM_FILT_W       9
`define CPM_FILT_LAST    9'(`CPM_FILT_CYC - 1)
`endif

// *** logic/cpm_pkg.sv ***
// Types for the CAN power-mode and bit-timing block.
// Assumes the constants header is on the include path.
`include "cpm_regs.svh"
package cpm_pkg;
	typedef enum logic [1:0] {
		CPM_NORMAL = 2'b00,
		CPM_SLEEP  = 2'b01,
		CPM_SOFT   = 2'b11,
		CPM_DOWN   = 2'b10
	} cpm_mode_t;
	typedef enum logic [1:0] {
		CPM_SEG_SYNC = 2'b00,
		CPM_SEG_ONE  = 2'b01,
		CPM_SEG_TWO  = 2'b11
	} cpm_seg_t;
endpackage : cpm_pkg

// *** verification/cpm_bus_node.sv ***
// Bus node model: pulls can_rx dominant for a commanded count of cycles.
// Assumes go is a one-cycle pulse driven away from the rising edge.
`timescale 1ns/100ps
module cpm_bus_node (
	// Control from bench
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic [9:0] dom_len,
	// Bus pin
	output logic            can_rx
);
	logic [9:0] left = 10'h000;
	always @(posedge mclk) begin
		if (go) left <= dom_len;
		else if (left != 10'h000) left <= left - 10'h001;
	end
	// Idle bus rests recessive through termination, never floats
	assign can_rx = (left == 10'h000);
endmodule : cpm_bus_node

// *** verification/cpm_core_asserts.sv ***
// Concurrent checks on the mode, wakeup and timing ports of cpm_core.
// Assumes it is bound to cpm_core and sees only its ports.
`timescale 1ns/100ps
module cpm_core_asserts (
	// Clock, reset and inputs
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic       cpu_stop,
	input wire logic       sleep_request_set,
	input wire logic       sleep_request_clr,
	input wire logic       cfg_we,
	input wire logic       timer_link_enable,
	input wire logic       wakeup_int_enable,
	// Outputs
	input wire logic       can_tx,
	input wire logic       sleep_request,
	input wire logic       sleep_ack,
	input wire logic       soft_reset_bit,
	input wire logic       wakeup_irq,
	input wire logic       reg_access_ok,
	input wire logic       proto_run,
	input wire logic       eng_abort,
	input wire logic       allow_copy,
	input wire logic       boff_count_en,
	input wire logic       bit_tick,
	input wire logic [3:0] first_segment_length,
	input wire logic [2:0] second_segment_length,
	input wire logic       capture_timer_one
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Mode register lags the stop level, so demand three cycles of it
	sequence s_stopped;
		cpu_stop [*3];
	endsequence
	a_tx_sleep_rec: assert property (sleep_ack |-> can_tx)
		else $error("can_tx not recessive in sleep");
	a_irq_gate_ok: assert property (wakeup_irq |-> sleep_ack && wakeup_int_enable)
		else $error("wakeup_irq without ack and enable");
	a_sleep_stops_proto: assert property (sleep_ack |-> !proto_run)
		else $error("protocol runs in sleep");
	a_sleep_no_copy: assert property (sleep_ack |-> !allow_copy && !eng_abort)
		else $error("copy or abort in sleep");
	a_boff_paused: assert property (sleep_ack |-> !boff_count_en)
		else $error("bus-off count runs in sleep");
	a_down_refuses: assert property (s_stopped |-> !reg_access_ok && can_tx)
		else $error("access or drive in power-down");
	a_clr_refused: assert property (sleep_request && !sleep_ack && sleep_request_clr
		&& !sleep_request_set |=> sleep_request)
		else $error("sleep request cleared before ack");
	a_cfg_locked: assert property (cfg_we && !soft_reset_bit |=>
		$stable(first_segment_length) && $stable(second_segment_length))
		else $error("timing written while online");
	a_soft_stops: assert property ($past(soft_reset_bit) && !$past(sys_rst)
		|-> !proto_run)
		else $error("protocol runs in soft reset");
	a_link_gated: assert property (!timer_link_enable && !$past(timer_link_enable)
		|-> !capture_timer_one)
		else $error("capture pulse with link off");
	a_bit_spacing: assert property (bit_tick |=> !bit_tick [*6])
		else $error("bit shorter than seven quanta");
endmodule : cpm_core_asserts

// *** verification/test_cpm_core.sv ***
// Self-checking bench for cpm_core with a bus node model on can_rx.
// Assumes cpm_core, cpm_core_asserts and cpm_bus_node are compiled first.
`timescale 1ns/100ps
module test_cpm_core import cpm_pkg::*;;
	logic mclk = 0, sys_rst = 1, cpu_stop = 0, cfg_we = 0, pll_ce = 0;
	logic sleep_request_set = 0, sleep_request_clr = 0, soft_reset_set = 0;
	logic soft_reset_clr = 0, wakeup_int_enable = 0, wakeup_filter_select = 0;
	logic timer_link_enable = 0, clock_source_select = 0, osc_ce = 1;
	logic eng_tx_pending = 0, eng_rx_busy = 0, eng_bus_off = 0, eng_tx = 0;
	logic eng_frame_valid = 0, bus_go = 0, can_rx;
	logic [9:0] bus_len = 10'h000;
	logic [5:0] cfg_prescale = 6'h01; // Two source enables per quantum
	logic [3:0] cfg_seg1 = 4'h0, first_segment_length;
	logic [2:0] cfg_seg2 = 3'h0, second_segment_length;
	logic [1:0] cfg_sjw = 2'h0, sjw_length;
	logic can_tx, sleep_request, sleep_ack, soft_reset_bit, wakeup_irq, cpu_wake;
	logic reg_access_ok, proto_run, eng_abort, allow_copy, bus_synced;
	logic boff_count_en, tq_tick, bit_tick, sample_point, capture_timer_one;
	int error_cnt = 0, num_checks = 0, i, p, c;
	// Rows: seg1 in, seg2 in, seg1 expected, seg2 expected (clamped)
	logic [15:0] rows [4] = '{16'h0031, 16'hF7F7, 16'h9494, 16'h3131};
	cpm_core dut_u (.*);
	cpm_bus_node bus_u (.mclk(mclk), .go(bus_go), .dom_len(bus_len),
		.can_rx(can_rx));
	initial forever #2 mclk = ~mclk;
	always @(negedge mclk) pll_ce <= ~pll_ce;
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic pls(ref logic s);
		s = 1;
		@(negedge mclk);
		s = 0;
	endtask : pls
	task automatic wt(ref logic s, input logic v, input int n);
		for (int k = 0; k < n && s !== v; k++) @(negedge mclk);
	endtask : wt
	task automatic cnt(ref logic s, input int n, output int h);
		h = 0;
		repeat (n) begin
			@(negedge mclk);
			if (s !== 1'b0) h++;
		end
	endtask : cnt
	task automatic per(output int q);
		wt(bit_tick, 1, 40);
		@(negedge mclk);
		q = 1;
		while (bit_tick !== 1'b1 && q < 60) begin
			@(negedge mclk);
			q++;
		end
	endtask : per
	task dom(input logic [9:0] n);
		bus_len = n;
		pls(bus_go);
	endtask : dom
	task sleep_now;
		pls(sleep_request_set);
		wt(sleep_ack, 1, 6);
	endtask : sleep_now
	initial begin
		#(20000 * 4);
		error_cnt++;
		summarize;
	end
	initial begin
		repeat (12) @(negedge mclk);
		sys_rst = 0;
		@(negedge mclk);
		chk("soft_rst", 1, soft_reset_bit);
		chk("tx_rst", 1, can_tx);
		for (i = 0; i < 4; i++) begin
			cfg_seg1 = rows[i][15:12];
			cfg_seg2 = rows[i][10:8];
			cfg_sjw = i[1:0];
			pls(cfg_we);
			@(negedge mclk);
			chk("seg1", rows[i][7:4], first_segment_length);
			chk("seg2", rows[i][2:0], second_segment_length);
			chk("sjw", i[1:0], sjw_length);
		end
		pls(soft_reset_clr);
		repeat (3) @(negedge mclk);
		chk("run", 1, proto_run);
		cnt(tq_tick, 14, c);
		chk("tq_rate", 7, c);
		cnt(sample_point, 28, c);
		chk("sample", 2, c);
		per(p);
		chk("bit_osc", 14, p);
		clock_source_select = 1;
		per(p);
		per(p);
		chk("bit_pll", 28, p);
		clock_source_select = 0;
		cfg_seg1 = 4'hF;
		pls(cfg_we);
		@(negedge mclk);
		chk("cfg_lock", 3, first_segment_length);
		eng_tx_pending = 1;
		eng_rx_busy = 1;
		eng_bus_off = 1;
		repeat (3) @(negedge mclk);
		pls(sleep_request_set);
		repeat (8) @(negedge mclk);
		chk("ack_wait", 0, sleep_ack);
		pls(sleep_request_clr);
		chk("clr_refused", 1, sleep_request);
		eng_tx_pending = 0;
		repeat (3) @(negedge mclk);
		chk("rx_wait", 0, sleep_ack);
		eng_rx_busy = 0;
		wt(sleep_ack, 1, 4);
		chk("ack", 1, sleep_ack);
		chk("tx_sleep", 1, can_tx);
		chk("proto_sleep", 0, proto_run);
		chk("boff_sleep", 0, boff_count_en);
		chk("copy_sleep", 0, allow_copy);
		wakeup_filter_select = 1;
		dom(10'h064);
		repeat (110) @(negedge mclk);
		chk("glitch", 1, sleep_ack);
		wakeup_int_enable = 1;
		dom(10'h258);
		wt(wakeup_irq, 1, 560);
		chk("irq", 1, wakeup_irq);
		wt(sleep_ack, 0, 4);
		chk("bus_wake", 0, sleep_ack);
		chk("no_sync", 0, bus_synced);
		wt(bus_synced, 1, 400);
		chk("synced", 1, bus_synced);
		chk("boff_resume", 1, boff_count_en);
		eng_bus_off = 0;
		sleep_now;
		wakeup_int_enable = 0;
		wakeup_filter_select = 0;
		dom(10'h014);
		cnt(wakeup_irq, 30, c);
		chk("irq_mask", 0, c);
		chk("short_wake", 0, sleep_ack);
		sleep_now;
		pls(sleep_request_clr);
		wt(sleep_ack, 0, 3);
		chk("clr_wake", 0, sleep_ack);
		sleep_now;
		pls(soft_reset_set);
		wt(sleep_ack, 0, 4);
		chk("soft_wake", 0, sleep_ack);
		chk("soft_stop", 0, proto_run);
		chk("soft_regs", 1, reg_access_ok);
		chk("soft_abort", 1, eng_abort);
		pls(soft_reset_clr);
		wt(sleep_ack, 1, 4);
		chk("soft_resleep", 1, sleep_ack);
		pls(sleep_request_clr);
		wt(sleep_ack, 0, 3);
		timer_link_enable = 1;
		pls(eng_frame_valid);
		cnt(capture_timer_one, 40, c);
		chk("link_on", 14, c);
		timer_link_enable = 0;
		pls(eng_frame_valid);
		cnt(capture_timer_one, 40, c);
		chk("link_off", 0, c);
		cpu_stop = 1;
		repeat (3) @(negedge mclk);
		chk("down_regs", 0, reg_access_ok);
		chk("down_tx", 1, can_tx);
		dom(10'h014);
		wt(cpu_wake, 1, 30);
		chk("cpu_wake", 1, cpu_wake);
		cpu_stop = 0;
		summarize;
	end
endmodule : test_cpm_core
bind cpm_core cpm_core_asserts chk_u (.*);
